// File: core/cdf_top.sv
/*
 * opcode decode and status flag logic of an 8-bit register-oriented core:
 * executes one opcode per exec_valid strobe, keeps the status byte and the
 * system control bits, evaluates branch conditions.
 * assumes operands are fetched by the surrounding core on the same clock.
 */
// Function
// - status byte: overflow bit 4, sign 5, zero 6, carry 7; branches test these.
// - overflow set when signed result leaves -128..+127.
// - logic operations always clear overflow.
// - sign copies result msb after arithmetic, logic, rotate, shift.
// - zero set when result is all zeros.
// - arithmetic carry marks carry out of or borrow into bit 7.
// - rotate and shift leave last shifted-out bit in carry.
// - single-byte ops set, clear, invert carry only.
// - moves leave flags alone and may write the status byte.
// - flag op targeting status byte collides; final value undefined.
// - status byte lives at register address D5H.
// - register operand 0..255; working register field 0..15.
// - register pairs sit at even addresses 0..254.
// - relative branch adds signed byte to next instruction address.
// - direct program addresses span 0..8191.
// - immediate operands are one byte 0..255.
// - two-operand ops chosen by upper nibble, forms by lower 2..6.
// - lower 2..6: r-r, r-Ir, R-R, R-IR, R-IM.
// - single-operand ops: lower 0 direct, 1 indirect; upper selects op.
// - lower 8,9,B,C,D,E are compact ops with register or condition.
// - lower F: idle, stop, irq off, irq on, return, irq exit, carry ops.
// - conditional branches use a 4-bit condition over C, Z, S, V.
// - irq on and off set and clear control bit 3.
`include "cdf_regs.svh"

module cdf_top import cdf_pkg::*; #(
	parameter int PC_W = 13
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic exec_valid,
	input wire logic [7:0] opcode,
	input wire logic [7:0] dst_addr,
	input wire logic [7:0] dst_val,
	input wire logic [7:0] src_val,
	input wire logic [PC_W-1:0] pc_next,
	input wire logic [PC_W-1:0] da_addr,
	input wire logic [7:0] rf_addr,
	input wire logic rf_we,
	input wire logic [7:0] rf_wdata,
	output logic [7:0] rf_rdata,
	output logic [7:0] status_byte,
	output logic irq_enable,
	output logic [7:0] res_data,
	output logic res_we,
	output logic [7:0] res_addr,
	output logic [7:0] pair_addr,
	output logic branch,
	output logic [PC_W-1:0] branch_tgt,
	output cdf_fam_t op_fam,
	output cdf_form_t op_form,
	output logic [3:0] work_reg,
	output logic idle_req,
	output logic stop_req,
	output logic return_req,
	output logic irq_exit_req
);

	// ****************************************
	// condition evaluation
	// ****************************************
	function automatic logic cdf_cond(input logic [3:0] cc, input logic [7:0] f);
		logic c;
		logic z;
		logic sv;
		c = f[`CDF_FLG_C];
		z = f[`CDF_FLG_Z];
		sv = f[`CDF_FLG_S] ^ f[`CDF_FLG_V];
		case (cc)
			4'h0: return 1'b0;
			4'h8: return 1'b1;
			4'h7: return c;
			4'hF: return !c;
			4'h6: return z;
			4'hE: return !z;
			4'hD: return !f[`CDF_FLG_S];
			4'h5: return f[`CDF_FLG_S];
			4'h4: return f[`CDF_FLG_V];
			4'hC: return !f[`CDF_FLG_V];
			4'h9: return !sv;
			4'h1: return sv;
			4'hA: return !(z | sv);
			4'h2: return z | sv;
			4'hB: return !c && !z;
			default: return c | z;
		endcase
	endfunction : cdf_cond

	// ****************************************
	// decode and alu
	// ****************************************
	cdf_st_t st_q;
	cdf_st_t st_d;
	cdf_fam_t fam;
	cdf_form_t form;
	cdf_alu_t alu_op;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_z;
	logic alu_s;
	logic alu_v;
	logic upd_zs;
	logic upd_c;
	logic upd_v;
	logic alu_wr;
	logic [3:0] un;

	assign un = opcode[7:4];

	cdf_decode u_dec (
		.opcode(opcode),
		.fam(fam),
		.form(form),
		.alu(alu_op)
	);

	cdf_alu u_alu (
		.op(alu_op),
		.a(dst_val),
		.b(src_val),
		.cin(st_q.flags[`CDF_FLG_C]),
		.res(alu_res),
		.c(alu_c),
		.z(alu_z),
		.s(alu_s),
		.v(alu_v),
		.upd_zs(upd_zs),
		.upd_c(upd_c),
		.upd_v(upd_v),
		.wr(alu_wr)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		st_d.br = 1'b0;
		st_d.res_we = 1'b0;
		st_d.idle = 1'b0;
		st_d.stop = 1'b0;
		st_d.retn = 1'b0;
		st_d.irqx = 1'b0;
		// status byte and control register are readable in the register file
		if (rf_addr == `CDF_ST_ADDR)
			st_d.rdata = st_q.flags;
		else if (rf_addr == `CDF_SYS_ADDR)
			st_d.rdata = {4'h0, st_q.ctl};
		else
			st_d.rdata = `CDF_ZERO8;
		if (rf_we && rf_addr == `CDF_ST_ADDR)
			st_d.flags = rf_wdata;
		if (rf_we && rf_addr == `CDF_SYS_ADDR)
			st_d.ctl = rf_wdata[3:0];
		if (exec_valid) begin
			st_d.fam = fam;
			st_d.form = form;
			st_d.wreg = un;
			st_d.res_addr = dst_addr;
			case (fam)
				CDF_F_ALU1, CDF_F_ALU2, CDF_F_INCR: begin
					st_d.res = alu_res;
					st_d.res_we = alu_wr;
					if (alu_wr && dst_addr == `CDF_ST_ADDR)
						st_d.flags = alu_res;
					// the flag update wins over the result write
					if (upd_zs) begin
						st_d.flags[`CDF_FLG_Z] = alu_z;
						st_d.flags[`CDF_FLG_S] = alu_s;
					end
					if (upd_v)
						st_d.flags[`CDF_FLG_V] = alu_v;
					if (upd_c)
						st_d.flags[`CDF_FLG_C] = alu_c;
				end
				CDF_F_LDR, CDF_F_STR, CDF_F_LDI, CDF_F_MOVE: begin
					st_d.res = src_val;
					st_d.res_we = 1'b1;
					if (dst_addr == `CDF_ST_ADDR)
						st_d.flags = src_val;
				end
				CDF_F_BREL: begin
					st_d.br = cdf_cond(un, st_q.flags);
					st_d.tgt = pc_next + {{(PC_W-8){src_val[7]}}, src_val};
				end
				CDF_F_BABS: begin
					st_d.br = cdf_cond(un, st_q.flags);
					st_d.tgt = da_addr;
				end
				CDF_F_CTRL: begin
					case (un)
						`CDF_CT_IDLE: st_d.idle = 1'b1;
						`CDF_CT_STOP: st_d.stop = 1'b1;
						`CDF_CT_IRQOFF: st_d.ctl[`CDF_SYS_IE] = 1'b0;
						`CDF_CT_IRQON: st_d.ctl[`CDF_SYS_IE] = 1'b1;
						`CDF_CT_RETN: st_d.retn = 1'b1;
						`CDF_CT_IRQX: begin
							st_d.irqx = 1'b1;
							st_d.ctl[`CDF_SYS_IE] = 1'b1;
						end
						`CDF_CT_CCLR: st_d.flags[`CDF_FLG_C] = 1'b0;
						`CDF_CT_CSET: st_d.flags[`CDF_FLG_C] = 1'b1;
						`CDF_CT_CINV: st_d.flags[`CDF_FLG_C] = !st_q.flags[`CDF_FLG_C];
						default: st_d.idle = 1'b0;
					endcase
				end
				default: st_d.res_we = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '{flags: `CDF_FLAGS_RST, ctl: `CDF_SYS_RST, fam: CDF_F_NONE, form: CDF_M_NONE, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rf_rdata = st_q.rdata;
	assign status_byte = st_q.flags;
	assign irq_enable = st_q.ctl[`CDF_SYS_IE];
	assign res_data = st_q.res;
	assign res_we = st_q.res_we;
	assign res_addr = st_q.res_addr;
	assign pair_addr = {st_q.res_addr[7:1], 1'b0};
	assign branch = st_q.br;
	assign branch_tgt = st_q.tgt;
	assign op_fam = st_q.fam;
	assign op_form = st_q.form;
	assign work_reg = st_q.wreg;
	assign idle_req = st_q.idle;
	assign stop_req = st_q.stop;
	assign return_req = st_q.retn;
	assign irq_exit_req = st_q.irqx;

	// ****************************************
	// checks
	// ****************************************
	logic flag_op;
	logic [8:0] add_sum;
	logic [8:0] add_cy;
	assign flag_op = exec_valid && upd_zs && (fam == CDF_F_ALU1 || fam == CDF_F_ALU2 || fam == CDF_F_INCR);
	assign add_sum = {dst_val[7], dst_val} + {src_val[7], src_val};
	// unsigned sum, its top bit is the carry out of bit 7
	assign add_cy = {1'b0, dst_val} + {1'b0, src_val};

	a_sign_copy: assert property (@(posedge mclk) disable iff (!rst_n)
		flag_op |=> status_byte[`CDF_FLG_S] == $past(alu_res[7]))
		else $error("sign flag does not match result msb");
	a_zero_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		flag_op |=> status_byte[`CDF_FLG_Z] == ($past(alu_res) == `CDF_ZERO8))
		else $error("zero flag wrong");
	a_logic_v_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		exec_valid && fam == CDF_F_ALU2 && (alu_op == CDF_A_AND || alu_op == CDF_A_OR || alu_op == CDF_A_XOR)
		|=> !status_byte[`CDF_FLG_V])
		else $error("overflow not cleared by logic op");
	a_add_ovf_range: assert property (@(posedge mclk) disable iff (!rst_n)
		exec_valid && fam == CDF_F_ALU2 && alu_op == CDF_A_ADD
		|=> status_byte[`CDF_FLG_V] == $past(add_sum[8] != add_sum[7]))
		else $error("overflow flag wrong after add");
	a_add_carry: assert property (@(posedge mclk) disable iff (!rst_n)
		exec_valid && fam == CDF_F_ALU2 && alu_op == CDF_A_ADD
		|=> status_byte[`CDF_FLG_C] == $past(add_cy[8]))
		else $error("carry flag wrong after add");
	a_carry_only: assert property (@(posedge mclk) disable iff (!rst_n)
		exec_valid && fam == CDF_F_CTRL && un == `CDF_CT_CSET && !rf_we
		|=> status_byte[`CDF_FLG_C] && status_byte[6:0] == $past(status_byte[6:0]))
		else $error("carry set touched other flags");
	a_move_keep: assert property (@(posedge mclk) disable iff (!rst_n)
		exec_valid && fam == CDF_F_MOVE && dst_addr != `CDF_ST_ADDR && !rf_we
		|=> $stable(status_byte))
		else $error("move changed the flags");
	a_irq_on_off: assert property (@(posedge mclk) disable iff (!rst_n)
		exec_valid && fam == CDF_F_CTRL && (un == `CDF_CT_IRQON || un == `CDF_CT_IRQOFF)
		|=> irq_enable == $past(un == `CDF_CT_IRQON)
		##1 irq_enable == $past(irq_enable) || $past(rf_we) || $past(exec_valid && fam == CDF_F_CTRL))
		else $error("irq enable bit wrong");
	a_ctrl_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
		exec_valid && fam == CDF_F_CTRL && un == `CDF_CT_RETN |=> return_req && !idle_req && !stop_req)
		else $error("return request missing");
	a_rel_target: assert property (@(posedge mclk) disable iff (!rst_n)
		exec_valid && fam == CDF_F_BREL
		|=> branch_tgt == $past(pc_next) + {{(PC_W-8){$past(src_val[7])}}, $past(src_val)})
		else $error("relative target wrong");
	a_never_false: assert property (@(posedge mclk) disable iff (!rst_n)
		exec_valid && (fam == CDF_F_BREL || fam == CDF_F_BABS) && un == 4'h0 |=> !branch)
		else $error("never condition branched");
	a_status_read: assert property (@(posedge mclk) disable iff (!rst_n)
		rf_addr == `CDF_ST_ADDR |=> rf_rdata == $past(status_byte))
		else $error("status read mismatch");
	a_shift_carry: assert property (@(posedge mclk) disable iff (!rst_n)
		exec_valid && fam == CDF_F_ALU1 && alu_op == CDF_A_ASHR |=> status_byte[`CDF_FLG_C] == $past(dst_val[0]))
		else $error("shift carry wrong");

endmodule : cdf_top

// File: core/cdf_regs.svh
/*
 * constants of the opcode decode and status flag block: register addresses,
 * status and control bit positions, reset values and opcode nibble codes.
 * assumes it is included once per compile unit through its guard.
 */
`ifndef CDF_REGS_SVH
`define CDF_REGS_SVH

// ****************************************
// register addresses and bits
// ****************************************
`define CDF_ST_ADDR 8'hD5
`define CDF_SYS_ADDR 8'hDF
`define CDF_FLG_C 7
`define CDF_FLG_Z 6
`define CDF_FLG_S 5
`define CDF_FLG_V 4
`define CDF_SYS_IE 3
`define CDF_FLAGS_RST 8'h00
`define CDF_SYS_RST 4'h0
`define CDF_ZERO8 8'h00
`define CDF_ONE8 8'h01

// ****************************************
// lower nibble codes
// ****************************************
`define CDF_LN_R 4'h0
`define CDF_LN_IR 4'h1
`define CDF_LN_WW 4'h2
`define CDF_LN_WI 4'h3
`define CDF_LN_RR 4'h4
`define CDF_LN_RI 4'h5
`define CDF_LN_IM 4'h6
`define CDF_LN_MV 4'h7
`define CDF_LN_LDR 4'h8
`define CDF_LN_STR 4'h9
`define CDF_LN_BREL 4'hB
`define CDF_LN_LDI 4'hC
`define CDF_LN_BABS 4'hD
`define CDF_LN_INCR 4'hE
`define CDF_LN_CTRL 4'hF

// ****************************************
// upper nibble codes
// ****************************************
`define CDF_U_ADD 4'h0
`define CDF_U_ADC 4'h1
`define CDF_U_SUB 4'h2
`define CDF_U_SUBB 4'h3
`define CDF_U_OR 4'h4
`define CDF_U_AND 4'h5
`define CDF_U_NTST 4'h6
`define CDF_U_MTST 4'h7
`define CDF_U_CMP 4'hA
`define CDF_U_XOR 4'hB
`define CDF_U_DECR 4'h0
`define CDF_U_ROLC 4'h1
`define CDF_U_INC 4'h2
`define CDF_U_POP 4'h5
`define CDF_U_INV 4'h6
`define CDF_U_PUSH 4'h7
`define CDF_U_ROL 4'h9
`define CDF_U_ZERO 4'hB
`define CDF_U_RORC 4'hC
`define CDF_U_ASHR 4'hD
`define CDF_U_ROR 4'hE
`define CDF_CT_IDLE 4'h6
`define CDF_CT_STOP 4'h7
`define CDF_CT_IRQOFF 4'h8
`define CDF_CT_IRQON 4'h9
`define CDF_CT_RETN 4'hA
`define CDF_CT_IRQX 4'hB
`define CDF_CT_CCLR 4'hC
`define CDF_CT_CSET 4'hD
`define CDF_CT_CINV 4'hE

`endif

// File: core/cdf_pkg.sv
/*
 * types of the opcode decode and status flag block.
 * assumes cdf_regs.svh is available on the include path.
 */
package cdf_pkg;

	typedef enum logic [3:0] {
		CDF_F_NONE = 4'h0, CDF_F_ALU2 = 4'h1, CDF_F_ALU1 = 4'h2, CDF_F_LDR = 4'h3,
		CDF_F_STR = 4'h4, CDF_F_BREL = 4'h5, CDF_F_LDI = 4'h6, CDF_F_BABS = 4'h7,
		CDF_F_INCR = 4'h8, CDF_F_CTRL = 4'h9, CDF_F_MOVE = 4'hA
	} cdf_fam_t;

	typedef enum logic [2:0] {
		CDF_M_NONE = 3'h0, CDF_M_WW = 3'h1, CDF_M_WI = 3'h2, CDF_M_RR = 3'h3,
		CDF_M_RI = 3'h4, CDF_M_IMM = 3'h5, CDF_M_DIR = 3'h6, CDF_M_IND = 3'h7
	} cdf_form_t;

	typedef enum logic [4:0] {
		CDF_A_ADD = 5'h00, CDF_A_ADC = 5'h01, CDF_A_SUB = 5'h02, CDF_A_SUBB = 5'h03,
		CDF_A_OR = 5'h04, CDF_A_AND = 5'h05, CDF_A_NTST = 5'h06, CDF_A_MTST = 5'h07,
		CDF_A_CMP = 5'h08, CDF_A_XOR = 5'h09, CDF_A_DECR = 5'h0A, CDF_A_INC = 5'h0B,
		CDF_A_ROLC = 5'h0C, CDF_A_ROL = 5'h0D, CDF_A_RORC = 5'h0E, CDF_A_ROR = 5'h0F,
		CDF_A_ASHR = 5'h10, CDF_A_INV = 5'h11, CDF_A_ZERO = 5'h12, CDF_A_PASS = 5'h13
	} cdf_alu_t;

	typedef struct packed {
		logic [7:0] flags;
		logic [3:0] ctl;
		logic [7:0] res;
		logic res_we;
		logic [7:0] res_addr;
		logic br;
		logic [12:0] tgt;
		cdf_fam_t fam;
		cdf_form_t form;
		logic [3:0] wreg;
		logic idle;
		logic stop;
		logic retn;
		logic irqx;
		logic [7:0] rdata;
	} cdf_st_t;

endpackage : cdf_pkg

// File: core/cdf_alu.sv
/*
 * combinational 8-bit alu with flag outputs and update masks.
 * assumes the caller registers results and applies the masks.
 */
`include "cdf_regs.svh"

module cdf_alu import cdf_pkg::*; (
	input wire cdf_alu_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	output logic [7:0] res,
	output logic c,
	output logic z,
	output logic s,
	output logic v,
	output logic upd_zs,
	output logic upd_c,
	output logic upd_v,
	output logic wr
);

	// returns {carry or borrow, overflow, result}
	function automatic logic [9:0] cdf_arith(input logic [7:0] x, input logic [7:0] y,
		input logic ci, input logic sub);
		logic [7:0] yy;
		logic [8:0] t;
		yy = sub ? ~y : y;
		t = {1'b0, x} + {1'b0, yy} + {8'h00, sub ^ ci};
		return {sub ^ t[8], (x[7] == yy[7]) && (t[7] != x[7]), t[7:0]};
	endfunction : cdf_arith

	logic [9:0] ar;

	always_comb begin
		ar = 10'h000;
		res = a;
		c = cin;
		v = 1'b0;
		upd_zs = 1'b1;
		upd_c = 1'b0;
		upd_v = 1'b1;
		wr = 1'b1;
		case (op)
			CDF_A_ADD: ar = cdf_arith(a, b, 1'b0, 1'b0);
			CDF_A_ADC: ar = cdf_arith(a, b, cin, 1'b0);
			CDF_A_SUB, CDF_A_CMP: ar = cdf_arith(a, b, 1'b0, 1'b1);
			CDF_A_SUBB: ar = cdf_arith(a, b, cin, 1'b1);
			CDF_A_DECR: ar = cdf_arith(a, `CDF_ONE8, 1'b0, 1'b1);
			CDF_A_INC: ar = cdf_arith(a, `CDF_ONE8, 1'b0, 1'b0);
			default: ar = 10'h000;
		endcase
		case (op)
			CDF_A_ADD, CDF_A_ADC, CDF_A_SUB, CDF_A_SUBB, CDF_A_CMP, CDF_A_DECR, CDF_A_INC: begin
				res = ar[7:0];
				v = ar[8];
				c = ar[9];
				upd_c = (op != CDF_A_DECR) && (op != CDF_A_INC);
				wr = (op != CDF_A_CMP);
			end
			CDF_A_OR: res = a | b;
			CDF_A_AND: res = a & b;
			CDF_A_XOR: res = a ^ b;
			CDF_A_INV: res = ~a;
			CDF_A_MTST: begin
				res = a & b;
				wr = 1'b0;
			end
			CDF_A_NTST: begin
				res = ~a & b;
				wr = 1'b0;
			end
			CDF_A_ROL, CDF_A_ROLC: begin
				res = {a[6:0], (op == CDF_A_ROL) ? a[7] : cin};
				c = a[7];
				v = a[7] ^ res[7];
				upd_c = 1'b1;
			end
			CDF_A_ROR, CDF_A_RORC: begin
				res = {(op == CDF_A_ROR) ? a[0] : cin, a[7:1]};
				c = a[0];
				v = a[7] ^ res[7];
				upd_c = 1'b1;
			end
			CDF_A_ASHR: begin
				res = {a[7], a[7:1]};
				c = a[0];
				upd_c = 1'b1;
			end
			CDF_A_ZERO: begin
				res = `CDF_ZERO8;
				upd_zs = 1'b0;
				upd_v = 1'b0;
			end
			default: begin
				res = b;
				upd_zs = 1'b0;
				upd_v = 1'b0;
			end
		endcase
		z = (res == `CDF_ZERO8);
		s = res[7];
	end

endmodule : cdf_alu

// File: core/cdf_decode.sv
/*
 * combinational opcode decoder: family, operand form and alu operation.
 * assumes one opcode byte presented per execute strobe.
 */
`include "cdf_regs.svh"

module cdf_decode import cdf_pkg::*; (
	input wire logic [7:0] opcode,
	output cdf_fam_t fam,
	output cdf_form_t form,
	output cdf_alu_t alu
);

	logic [3:0] ln;
	logic [3:0] un;

	always_comb begin
		ln = opcode[3:0];
		un = opcode[7:4];
		fam = CDF_F_NONE;
		form = CDF_M_NONE;
		alu = CDF_A_PASS;
		case (ln)
			`CDF_LN_R, `CDF_LN_IR: begin
				form = (ln == `CDF_LN_R) ? CDF_M_DIR : CDF_M_IND;
				fam = CDF_F_ALU1;
				case (un)
					`CDF_U_DECR: alu = CDF_A_DECR;
					`CDF_U_ROLC: alu = CDF_A_ROLC;
					`CDF_U_INC: alu = CDF_A_INC;
					`CDF_U_INV: alu = CDF_A_INV;
					`CDF_U_ROL: alu = CDF_A_ROL;
					`CDF_U_ZERO: alu = CDF_A_ZERO;
					`CDF_U_RORC: alu = CDF_A_RORC;
					`CDF_U_ASHR: alu = CDF_A_ASHR;
					`CDF_U_ROR: alu = CDF_A_ROR;
					`CDF_U_POP, `CDF_U_PUSH: fam = CDF_F_MOVE;
					default: begin
						fam = CDF_F_NONE;
						form = CDF_M_NONE;
					end
				endcase
			end
			`CDF_LN_WW, `CDF_LN_WI, `CDF_LN_RR, `CDF_LN_RI, `CDF_LN_IM: begin
				case (ln)
					`CDF_LN_WW: form = CDF_M_WW;
					`CDF_LN_WI: form = CDF_M_WI;
					`CDF_LN_RR: form = CDF_M_RR;
					`CDF_LN_RI: form = CDF_M_RI;
					default: form = CDF_M_IMM;
				endcase
				fam = CDF_F_ALU2;
				case (un)
					`CDF_U_ADD: alu = CDF_A_ADD;
					`CDF_U_ADC: alu = CDF_A_ADC;
					`CDF_U_SUB: alu = CDF_A_SUB;
					`CDF_U_SUBB: alu = CDF_A_SUBB;
					`CDF_U_OR: alu = CDF_A_OR;
					`CDF_U_AND: alu = CDF_A_AND;
					`CDF_U_NTST: alu = CDF_A_NTST;
					`CDF_U_MTST: alu = CDF_A_MTST;
					`CDF_U_CMP: alu = CDF_A_CMP;
					`CDF_U_XOR: alu = CDF_A_XOR;
					default: fam = CDF_F_MOVE;
				endcase
			end
			`CDF_LN_MV: fam = CDF_F_MOVE;
			`CDF_LN_LDR: fam = CDF_F_LDR;
			`CDF_LN_STR: fam = CDF_F_STR;
			`CDF_LN_BREL: fam = CDF_F_BREL;
			`CDF_LN_LDI: begin
				fam = CDF_F_LDI;
				form = CDF_M_IMM;
			end
			`CDF_LN_BABS: fam = CDF_F_BABS;
			`CDF_LN_INCR: begin
				fam = CDF_F_INCR;
				alu = CDF_A_INC;
			end
			`CDF_LN_CTRL: fam = CDF_F_CTRL;
			default: fam = CDF_F_NONE;
		endcase
	end

endmodule : cdf_decode

// File: bench/cdf_rfm.sv
/*
 * register file model on the write-back side of cdf_top: stores every
 * result write and offers a read port to the bench.
 * assumes res_we is a one-cycle pulse sampled on the rising mclk edge.
 */
module cdf_rfm (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic res_we,
	input wire logic [7:0] res_addr,
	input wire logic [7:0] res_data,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] mem [256];

	// ****************************************
	// storage
	// ****************************************
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			foreach (mem[i]) mem[i] <= 8'h00;
		end else if (res_we) begin
			mem[res_addr] <= res_data;
		end
	end

	assign rd_data = mem[rd_addr];
endmodule : cdf_rfm

// File: bench/test_cdf_top.sv
/*
 * self-checking bench for cdf_top: exec and register tasks, table driven.
 * assumes cdf_pkg, cdf_regs.svh and cdf_rfm are compiled beforehand.
 */
`include "cdf_regs.svh"

module test_cdf_top import cdf_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;

	logic mclk, rst_n, exec_valid, rf_we, res_we, branch, irq_enable;
	logic idle_req, stop_req, return_req, irq_exit_req;
	logic [7:0] opcode, dst_addr, dst_val, src_val, rf_addr, rf_wdata, rf_rdata;
	logic [7:0] status_byte, res_data, res_addr, pair_addr, rd_addr, rd_data;
	logic [12:0] pc_next, da_addr, branch_tgt;
	logic [3:0] work_reg;
	cdf_fam_t op_fam;
	cdf_form_t op_form;
	int error_cnt, checks, cyc;
	logic [7:0] cop [4] = '{8'hDF, 8'hEF, 8'hEF, 8'hCF};
	logic [7:0] cex [4] = '{8'hFF, 8'h7F, 8'hFF, 8'h7F};
	logic [7:0] pop [4] = '{8'h6F, 8'h7F, 8'hAF, 8'hBF};
	logic [3:0] aup [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hB, 4'h6, 4'h7, 4'hA};
	logic [7:0] aex [10] = '{8'h16, 8'h16, 8'h02, 8'h02, 8'h0E, 8'h08, 8'h06, 8'h02, 8'h08, 8'h02};
	logic [7:0] sop [9] = '{8'h00, 8'h10, 8'h20, 8'h60, 8'h90, 8'hB0, 8'hC0, 8'hD0, 8'hE0};
	logic [7:0] sres [9] = '{8'h80, 8'h02, 8'h82, 8'h7E, 8'h03, 8'h00, 8'hC0, 8'hC0, 8'hC0};
	logic [7:0] dop [14] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h00, 8'h01,
		8'h08, 8'h09, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h6F};
	cdf_fam_t dfam [14] = '{CDF_F_ALU2, CDF_F_ALU2, CDF_F_ALU2, CDF_F_ALU2, CDF_F_ALU2,
		CDF_F_ALU1, CDF_F_ALU1, CDF_F_LDR, CDF_F_STR, CDF_F_BREL, CDF_F_LDI, CDF_F_BABS,
		CDF_F_INCR, CDF_F_CTRL};
	cdf_form_t dform [7] = '{CDF_M_WW, CDF_M_WI, CDF_M_RR, CDF_M_RI, CDF_M_IMM, CDF_M_DIR, CDF_M_IND};

	cdf_top uut (.mclk(mclk), .rst_n(rst_n), .exec_valid(exec_valid), .opcode(opcode),
		.dst_addr(dst_addr), .dst_val(dst_val), .src_val(src_val), .pc_next(pc_next),
		.da_addr(da_addr), .rf_addr(rf_addr), .rf_we(rf_we), .rf_wdata(rf_wdata),
		.rf_rdata(rf_rdata), .status_byte(status_byte), .irq_enable(irq_enable),
		.res_data(res_data), .res_we(res_we), .res_addr(res_addr), .pair_addr(pair_addr),
		.branch(branch), .branch_tgt(branch_tgt), .op_fam(op_fam), .op_form(op_form),
		.work_reg(work_reg), .idle_req(idle_req), .stop_req(stop_req), .return_req(return_req),
		.irq_exit_req(irq_exit_req));

	cdf_rfm rfm (.mclk(mclk), .rst_n(rst_n), .res_we(res_we), .res_addr(res_addr),
		.res_data(res_data), .rd_addr(rd_addr), .rd_data(rd_data));

	// ****************************************
	// clock, timeout and tasks
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// exec_valid stays high so calls run back to back; rest lowers it
	task automatic exec(input logic [7:0] op, input logic [7:0] da, input logic [7:0] dv, input logic [7:0] sv);
		exec_valid = 1'b1;
		opcode = op;
		dst_addr = da;
		dst_val = dv;
		src_val = sv;
		@(posedge mclk);
		#5;
	endtask : exec

	task automatic rest();
		exec_valid = 1'b0;
		@(posedge mclk);
		#5;
	endtask : rest

	task automatic rf_wr(input logic [7:0] a, input logic [7:0] d);
		rf_addr = a;
		rf_wdata = d;
		rf_we = 1'b1;
		@(posedge mclk);
		#5;
		rf_we = 1'b0;
		@(posedge mclk);
		#5;
	endtask : rf_wr

	task automatic rf_rd(input logic [7:0] a, input logic [7:0] exp);
		rf_addr = a;
		@(posedge mclk);
		#5;
		chk(rf_rdata, exp);
	endtask : rf_rd

	// ****************************************
	// tests
	// ****************************************
	initial begin
		{exec_valid, rf_we, opcode, dst_addr, dst_val, src_val, rf_addr, rf_wdata} = '0;
		pc_next = 13'h0100;
		da_addr = 13'h1FFF;
		rd_addr = 8'h10;
		rst_n = 1'b0;
		repeat (8) @(posedge mclk);
		#5;
		rst_n = 1'b1;
		chk(status_byte, 8'h00);
		chk(irq_enable, 1'b0);
		chk(op_fam, CDF_F_NONE);
		$display("test reset done");
		exec(8'h02, 8'h10, 8'h7F, 8'h01);
		chk(res_data, 8'h80);
		chk(res_we, 1'b1);
		chk(status_byte, 8'h30);
		rest();
		chk(rd_data, 8'h80);
		chk(res_we, 1'b0);
		exec(8'h02, 8'h13, 8'hFF, 8'h01);
		chk(status_byte, 8'hC0);
		chk(pair_addr, 8'h12);
		chk(res_addr, 8'h13);
		exec(8'h22, 8'h10, 8'h00, 8'h01);
		chk(res_data, 8'hFF);
		chk(status_byte, 8'hA0);
		exec(8'h02, 8'h10, 8'h7F, 8'h01);
		exec(8'h52, 8'h10, 8'h0F, 8'hF0);
		chk(status_byte, 8'h40);
		exec(8'h90, 8'h10, 8'h80, 8'h00);
		chk(res_data, 8'h01);
		chk(status_byte, 8'h90);
		exec(8'hD0, 8'h10, 8'h81, 8'h00);
		chk(status_byte, 8'hA0);
		rest();
		$display("test flags done");
		rf_wr(`CDF_ST_ADDR, 8'h7F);
		for (int i = 0; i < 4; i++) begin
			exec(cop[i], 8'h10, 8'h00, 8'h00);
			chk(status_byte, cex[i]);
		end
		exec(8'h0C, 8'h20, 8'h00, 8'h80);
		chk(status_byte, 8'h7F);
		exec(8'h0C, `CDF_ST_ADDR, 8'h00, 8'h5A);
		chk(res_data, 8'h5A);
		chk(status_byte, 8'h5A);
		rest();
		rf_wr(`CDF_ST_ADDR, 8'hA5);
		rf_rd(`CDF_ST_ADDR, 8'hA5);
		rf_rd(8'h33, 8'h00);
		$display("test carry and moves done");
		exec(8'h9F, 8'h00, 8'h00, 8'h00);
		chk(irq_enable, 1'b1);
		rest();
		rf_rd(`CDF_SYS_ADDR, 8'h08);
		exec(8'h8F, 8'h00, 8'h00, 8'h00);
		chk(irq_enable, 1'b0);
		for (int i = 0; i < 4; i++) begin
			exec(pop[i], 8'h00, 8'h00, 8'h00);
			chk({idle_req, stop_req, return_req, irq_exit_req}, 4'h8 >> i);
		end
		chk(irq_enable, 1'b1);
		rest();
		chk({idle_req, stop_req, return_req, irq_exit_req}, 4'h0);
		$display("test control done");
		rf_wr(`CDF_ST_ADDR, 8'h00);
		exec(8'h8B, 8'h00, 8'h00, 8'hFE);
		chk(branch, 1'b1);
		chk(branch_tgt, 13'h00FE);
		exec(8'h0B, 8'h00, 8'h00, 8'h10);
		chk(branch, 1'b0);
		exec(8'h7B, 8'h00, 8'h00, 8'h10);
		chk(branch, 1'b0);
		exec(8'hDF, 8'h00, 8'h00, 8'h00);
		exec(8'h7B, 8'h00, 8'h00, 8'h7F);
		chk(branch, 1'b1);
		chk(branch_tgt, 13'h017F);
		exec(8'h02, 8'h10, 8'hFF, 8'h01);
		exec(8'h6B, 8'h00, 8'h00, 8'h80);
		chk(branch, 1'b1);
		chk(branch_tgt, 13'h0080);
		exec(8'h8D, 8'h00, 8'h00, 8'h00);
		chk(branch_tgt, 13'h1FFF);
		rest();
		chk(branch, 1'b0);
		$display("test branch done");
		rf_wr(`CDF_ST_ADDR, 8'h00);
		for (int i = 0; i < 10; i++) begin
			exec({aup[i], 4'h6}, 8'h10, 8'h0C, 8'h0A);
			chk(res_data, aex[i]);
			chk(res_we, i < 7);
		end
		// carry is clear after the compare, so the left through-carry rotate starts from 0; the right one gets 1 from the rotate left
		for (int i = 0; i < 9; i++) begin
			exec(sop[i], 8'h10, 8'h81, 8'h00);
			chk(res_data, sres[i]);
		end
		for (int i = 0; i < 14; i++) begin
			exec(dop[i], 8'h10, 8'h01, 8'h01);
			chk(op_fam, dfam[i]);
			if (i < 7) chk(op_form, dform[i]);
			chk(work_reg, dop[i][7:4]);
		end
		rest();
		$display("test decode done");
		end_sim();
	end
endmodule : test_cdf_top
